/* hw/uart_rx_params.svh */
// Register offsets, field positions, reset values and timing counts of the receive channel
`ifndef UART_RX_PARAMS_SVH
`define UART_RX_PARAMS_SVH
`define OFS_RX_HOLDING   8'h00
`define OFS_TX_HOLDING   8'h04
`define OFS_INT_ENABLE   8'h08
`define OFS_FIFO_CTRL    8'h0c
`define OFS_LINE_CTRL    8'h10
`define OFS_MODEM_CTRL   8'h14
`define OFS_LINE_STATUS  8'h18
`define OFS_INT_STATUS   8'h1c
`define OFS_BAUD_DIV     8'h20
`define OFS_MODEM_STATUS 8'h24
`define OFS_IR_CTRL      8'h28
`define OFS_ENH_MULTI    8'hf0
`define OFS_SLAVE_ADDR   8'hf4
`define IER_RX_DATA      0
`define IER_LINE_STAT    2
`define FCR_ENABLE       0
`define FCR_RX_RESET     1
`define LCR_PAR_EN       3
`define LCR_PAR_EVEN     4
`define LCR_NINTH        5
`define MCR_DTR          0
`define MCR_RTS          1
`define MCR_LOOP         4
`define EM_AUTO_485      4
`define EM_485_INV       5
`define EM_ADDR_DET      6
`define EM_MULTIDROP     7
`define IR_RX_IDLE_HI    0
`define IR_TX_IDLE_HI    1
`define IR_FIXED_PULSE   2
`define IR_ENABLE        4
`define REG_RESET        8'h00
`define DIV_RESET        16'h0004
`define START_MID        4'h7
`define LAST_TICK        4'hf
`define IR_PULSE_TICKS   4'h3
`define IR_HOLD_TICKS    5'h10
`define TIMEOUT_WORDS    4
`define TIMEOUT_BITS     12
`define CLK_PERIOD_NS    100
`define IR_PULSE_NS      1600
`define IR_PULSE_CYC     ((`IR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRIG_0           8'h01
`define TRIG_1           8'h20
`define TRIG_2           8'h40
`define TRIG_3           8'h78
`endif

/* hw/uart_rx_pkg.sv */
// State types of the receive channel
package uart_rx_pkg;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_SHIFT} tx_state_t;
endpackage : uart_rx_pkg

/* hw/uart_rx_line.sv */
// One UART channel: receiver, receive FIFO, line modes and AXI4-Lite registers
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "uart_rx_params.svh"
// Overview of operation
// - Start edge, recheck line low after eight ticks
// - Every later bit sampled at its centre
// - Parity, framing, break shown in status 2-4
// - Holding read advances pointer, head tags shown
// - Data interrupt per character or at trigger
// - Timeout after four words plus twelve bits
// - FIFO of 128 entries, data plus tags
// - Holding register shows oldest unread character
// - Direction released after last stop bit
// - Direction asserted before first transmitted bit
// - Bit five inverts direction polarity
// - Multidrop: ninth bit is address flag
// - Multidrop parity tag equals ninth bit
// - Address detection compares with slave address
// - Mismatched address and its data dropped
// - Matching address stored, tagged, line interrupt
// - Infrared pulse 3/16 bit or 1.6 us
// - Infrared path only when enabled
// - Infrared idle levels chosen by bits 0, 1
// - Each light pulse decodes as zero
// - Loopback feeds transmit into receive
// - Loopback: mark out, outputs off, inputs ignored
module uart_rx_line #(
  parameter int FIFO_DEPTH = 128,
  parameter int PTR_W      = 7
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        serial_rx_in,
  output logic             serial_tx_out,
  input  wire logic        infrared_rx_in,
  output logic             infrared_tx_out,
  output logic             direction_control_out,
  output logic             dtr_n_out,
  input  wire logic [3:0]  modem_status_n_in,
  output logic             rx_data_irq,
  output logic             rx_timeout_irq,
  output logic             line_status_irq
);
  import uart_rx_pkg::*;

  logic [7:0]       int_enable, fifo_ctrl, line_ctrl, modem_ctrl, ir_ctrl, enh_multi, slave_addr;
  logic [15:0]      baud_div, div_cnt;
  logic [1:0]       rx_sync, ir_sync;
  logic [3:0]       ms_s1, ms_s2;
  logic             tick, loop, ir_en, multidrop, auto_addr, auto_485;
  logic             aw_held, w_held, do_write, rd_fire, rd_ok, wr_ok;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data, next_rdata;
  logic [3:0]       w_strb;
  logic [7:0]       tx_hold;
  logic             tx_hold_full, tx_line, tx_active, tx_bit_start, tx_par, ir_pulse;
  tx_state_t        tx_state;
  logic [10:0]      tx_shift, next_frame;
  logic [3:0]       tx_left, tx_sub, frame_len;
  logic [4:0]       ir_cyc, ir_hold;
  logic             ir_in_pulse, ir_bit, rx_bit, rx_prev;
  rx_state_t        rx_state;
  logic [3:0]       rx_sub;
  logic [2:0]       rx_cnt, last_idx;
  logic [7:0]       rx_data, data_mask;
  logic             rx_par, rx_done, par_err, frm_err, brk, is_addr, match, addr_ok, store;
  logic [10:0]      fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr, rd_ptr;
  logic [PTR_W:0]   count, limit;
  logic             push, pop, full, fifo_clr, overrun, addr_flag, timeout;
  logic [2:0]       head_tags;
  logic [9:0]       to_cnt, to_limit;
  logic [5:0]       to_bits;
  logic [7:0]       trig, line_status_register;

  assign loop      = modem_ctrl[`MCR_LOOP];
  assign ir_en     = ir_ctrl[`IR_ENABLE];
  assign multidrop = enh_multi[`EM_MULTIDROP];
  assign auto_addr = multidrop & enh_multi[`EM_ADDR_DET];
  assign auto_485  = enh_multi[`EM_AUTO_485];

  // Pin synchronisers, two flops each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync <= 2'h3;
      ir_sync <= 2'h0;
      ms_s1   <= 4'hf;
      ms_s2   <= 4'hf;
    end else begin
      rx_sync <= {rx_sync[0], serial_rx_in};
      ir_sync <= {ir_sync[0], infrared_rx_in};
      ms_s1   <= modem_status_n_in;
      ms_s2   <= ms_s1;
    end
  end

  // 16x sampling tick from the divisor
  always_ff @(posedge aclk) begin
    if (!aresetn)
      div_cnt <= 16'h0000;
    else if (tick)
      div_cnt <= baud_div;
    else
      div_cnt <= div_cnt - 16'h0001;
  end
  assign tick = (div_cnt == 16'h0000);

  // AXI4-Lite write address and data capture, either order
  assign awready  = !aw_held && !bvalid;
  assign wready   = !w_held && !bvalid;
  assign do_write = aw_held && w_held;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Writable register decode
  always_comb begin
    unique case (aw_addr)
      `OFS_TX_HOLDING, `OFS_INT_ENABLE, `OFS_FIFO_CTRL, `OFS_LINE_CTRL, `OFS_MODEM_CTRL,
      `OFS_BAUD_DIV, `OFS_IR_CTRL, `OFS_ENH_MULTI, `OFS_SLAVE_ADDR: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Control registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_enable <= `REG_RESET;
      fifo_ctrl  <= `REG_RESET;
      line_ctrl  <= `REG_RESET;
      modem_ctrl <= `REG_RESET;
      ir_ctrl    <= `REG_RESET;
      enh_multi  <= `REG_RESET;
      slave_addr <= `REG_RESET;
      baud_div   <= `DIV_RESET;
    end else if (do_write) begin
      if (w_strb[0]) begin
        unique case (aw_addr)
          `OFS_INT_ENABLE: int_enable <= w_data[7:0];
          `OFS_FIFO_CTRL:  fifo_ctrl  <= {w_data[7:2], 1'b0, w_data[0]};
          `OFS_LINE_CTRL:  line_ctrl  <= w_data[7:0];
          `OFS_MODEM_CTRL: modem_ctrl <= w_data[7:0];
          `OFS_IR_CTRL:    ir_ctrl    <= w_data[7:0];
          `OFS_ENH_MULTI:  enh_multi  <= w_data[7:0];
          `OFS_SLAVE_ADDR: slave_addr <= w_data[7:0];
          `OFS_BAUD_DIV:   baud_div[7:0] <= w_data[7:0];
          default: ;
        endcase
      end
      if (w_strb[1] && aw_addr == `OFS_BAUD_DIV)
        baud_div[15:8] <= w_data[15:8];
    end
  end
  assign fifo_clr = do_write && w_strb[0] && aw_addr == `OFS_FIFO_CTRL &&
                    (w_data[`FCR_RX_RESET] || w_data[`FCR_ENABLE] != fifo_ctrl[`FCR_ENABLE]);

  // Transmit frame: start, data, optional parity or address flag, stop
  always_comb begin
    next_frame = 11'h7ff;
    next_frame[0] = 1'b0;
    for (int i = 0; i < 8; i++)
      if (3'(i) <= last_idx)
        next_frame[i+1] = tx_hold[i];
    if (line_ctrl[`LCR_PAR_EN] || multidrop)
      next_frame[4'(last_idx) + 4'h2] = tx_par;
  end
  assign last_idx  = 3'h4 + {1'b0, line_ctrl[1:0]};
  assign data_mask = 8'hff >> (3'h7 - last_idx);
  assign tx_par    = multidrop ? line_ctrl[`LCR_NINTH] :
                     (^(tx_hold & data_mask)) ^ !line_ctrl[`LCR_PAR_EVEN];
  assign frame_len = 4'h3 + {1'b0, last_idx} + {3'h0, line_ctrl[`LCR_PAR_EN] | multidrop};

  // Transmitter with a lead state so direction leads the start bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state     <= TX_IDLE;
      tx_hold      <= 8'h00;
      tx_hold_full <= 1'b0;
      tx_shift     <= 11'h7ff;
      tx_left      <= 4'h0;
      tx_sub       <= 4'h0;
    end else begin
      if (do_write && w_strb[0] && aw_addr == `OFS_TX_HOLDING) begin
        tx_hold      <= w_data[7:0];
        tx_hold_full <= 1'b1;
      end
      unique case (tx_state)
        TX_IDLE: if (tx_hold_full) tx_state <= TX_LEAD;
        TX_LEAD: if (tick) begin
          tx_state     <= TX_SHIFT;
          tx_shift     <= next_frame;
          tx_left      <= frame_len;
          tx_sub       <= 4'h0;
          tx_hold_full <= 1'b0;
        end
        TX_SHIFT: if (tick) begin
          tx_sub <= tx_sub + 4'h1;
          if (tx_sub == `LAST_TICK) begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_left  <= tx_left - 4'h1;
            if (tx_left == 4'h1)
              tx_state <= TX_IDLE;
          end
        end
      endcase
    end
  end
  assign tx_line      = (tx_state == TX_SHIFT) ? tx_shift[0] : 1'b1;
  assign tx_active    = (tx_state != TX_IDLE) || tx_hold_full;
  assign tx_bit_start = tick && (tx_state == TX_LEAD ||
                        (tx_state == TX_SHIFT && tx_sub == `LAST_TICK && tx_left != 4'h1));

  // Fixed-width infrared pulse timer, restarted per bit
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ir_cyc <= 5'h00;
    else if (tx_bit_start)
      ir_cyc <= 5'(`IR_PULSE_CYC);
    else if (ir_cyc != 5'h00)
      ir_cyc <= ir_cyc - 5'h01;
  end
  assign ir_pulse = (tx_state == TX_SHIFT) && !tx_shift[0] &&
                    (ir_ctrl[`IR_FIXED_PULSE] ? (ir_cyc != 5'h00) : (tx_sub < `IR_PULSE_TICKS));

  // Line outputs, forced quiet in loopback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_tx_out         <= 1'b1;
      infrared_tx_out       <= 1'b0;
      direction_control_out <= 1'b1;
      dtr_n_out             <= 1'b1;
    end else begin
      serial_tx_out   <= loop | tx_line;
      infrared_tx_out <= (ir_en && !loop && ir_pulse) ^ ir_ctrl[`IR_TX_IDLE_HI];
      dtr_n_out       <= loop | !modem_ctrl[`MCR_DTR];
      if (auto_485)
        direction_control_out <= (tx_active && !loop) ^ enh_multi[`EM_485_INV];
      else
        direction_control_out <= loop | !modem_ctrl[`MCR_RTS];
    end
  end

  // Infrared decoder: a pulse holds a zero for one bit time
  assign ir_in_pulse = ir_sync[1] ^ ir_ctrl[`IR_RX_IDLE_HI];
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ir_hold <= 5'h00;
    else if (ir_in_pulse)
      ir_hold <= `IR_HOLD_TICKS;
    else if (tick && ir_hold != 5'h00)
      ir_hold <= ir_hold - 5'h01;
  end
  assign ir_bit = !ir_in_pulse && (ir_hold == 5'h00);
  assign rx_bit = loop ? tx_line : (ir_en ? ir_bit : rx_sync[1]);

  // Receiver: start validation then centre sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= RX_IDLE;
      rx_prev  <= 1'b1;
      rx_sub   <= 4'h0;
      rx_cnt   <= 3'h0;
      rx_data  <= 8'h00;
      rx_par   <= 1'b0;
    end else begin
      rx_prev <= rx_bit;
      unique case (rx_state)
        RX_IDLE: if (rx_prev && !rx_bit) begin
          rx_state <= RX_START;
          rx_sub   <= 4'h0;
        end
        RX_START: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == `START_MID) begin
            rx_state <= rx_bit ? RX_IDLE : RX_DATA;
            rx_sub   <= 4'h0;
            rx_cnt   <= 3'h0;
            rx_data  <= 8'h00;
            rx_par   <= 1'b0;
          end
        end
        RX_DATA: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == `LAST_TICK) begin
            rx_data[rx_cnt] <= rx_bit;
            rx_cnt          <= rx_cnt + 3'h1;
            if (rx_cnt == last_idx)
              rx_state <= (line_ctrl[`LCR_PAR_EN] || multidrop) ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == `LAST_TICK) begin
            rx_par   <= rx_bit;
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == `LAST_TICK)
            rx_state <= RX_IDLE;
        end
      endcase
    end
  end
  assign rx_done = (rx_state == RX_STOP) && tick && (rx_sub == `LAST_TICK);
  assign frm_err = !rx_bit;
  assign brk     = !rx_bit && rx_data == 8'h00 && !rx_par;
  assign par_err = multidrop ? rx_par :
                   line_ctrl[`LCR_PAR_EN] && (rx_par ^ (^rx_data) ^ !line_ctrl[`LCR_PAR_EVEN]);

  // Address filter for multidrop
  assign is_addr = multidrop && rx_par;
  assign match   = (rx_data == slave_addr);
  assign store   = !auto_addr || (is_addr ? match : addr_ok);
  always_ff @(posedge aclk) begin
    if (!aresetn)
      addr_ok <= 1'b0;
    else if (!auto_addr)
      addr_ok <= 1'b0;
    else if (rx_done && is_addr)
      addr_ok <= match;
  end

  // Receive FIFO storage, data plus three tags
  assign limit = fifo_ctrl[`FCR_ENABLE] ? (PTR_W+1)'(FIFO_DEPTH) : (PTR_W+1)'(1);
  assign full  = (count >= limit);
  assign push  = rx_done && store && !full;
  assign pop   = rd_fire && araddr == `OFS_RX_HOLDING && count != '0;
  always_ff @(posedge aclk) begin
    if (push)
      fifo_mem[wr_ptr] <= {brk, frm_err, par_err, rx_data};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || fifo_clr) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + PTR_W'(1);
      if (pop)
        rd_ptr <= rd_ptr + PTR_W'(1);
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
  assign head_tags = (count != '0) ? fifo_mem[rd_ptr][10:8] : 3'h0;

  // Sticky overrun and address-match flags, set wins over read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun   <= 1'b0;
      addr_flag <= 1'b0;
    end else begin
      overrun   <= (rx_done && store && full) ||
                   (overrun && !(rd_fire && araddr == `OFS_LINE_STATUS));
      addr_flag <= (rx_done && auto_addr && is_addr && match) ||
                   (addr_flag && !(rd_fire && araddr == `OFS_LINE_STATUS));
    end
  end

  // Character timeout counter in sampling ticks
  assign to_bits  = 6'(`TIMEOUT_WORDS * ({2'h0, line_ctrl[1:0]} + 4'h5) + `TIMEOUT_BITS);
  assign to_limit = {to_bits, 4'h0};
  always_ff @(posedge aclk) begin
    if (!aresetn || push || pop || count == '0)
      to_cnt <= 10'h000;
    else if (tick && to_cnt != to_limit)
      to_cnt <= to_cnt + 10'h001;
  end
  assign timeout = (to_cnt == to_limit) && (count != '0);

  // Interrupt outputs
  always_comb begin
    unique case (fifo_ctrl[7:6])
      2'h0: trig = `TRIG_0;
      2'h1: trig = `TRIG_1;
      2'h2: trig = `TRIG_2;
      2'h3: trig = `TRIG_3;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_irq     <= 1'b0;
      rx_timeout_irq  <= 1'b0;
      line_status_irq <= 1'b0;
    end else begin
      rx_data_irq     <= int_enable[`IER_RX_DATA] && (fifo_ctrl[`FCR_ENABLE] ?
                         ({1'b0, count} >= {1'b0, trig}) : (count != '0));
      rx_timeout_irq  <= int_enable[`IER_RX_DATA] && timeout;
      line_status_irq <= int_enable[`IER_LINE_STAT] &&
                         (overrun || addr_flag || head_tags != 3'h0);
    end
  end

  // Register read mux and read channel
  assign line_status_register = {1'b0, !tx_active, !tx_hold_full, head_tags, overrun, count != '0};
  always_comb begin
    rd_ok      = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (araddr)
      `OFS_RX_HOLDING:   next_rdata[7:0] = fifo_mem[rd_ptr][7:0];
      `OFS_INT_ENABLE:   next_rdata[7:0] = int_enable;
      `OFS_FIFO_CTRL:    next_rdata[7:0] = fifo_ctrl;
      `OFS_LINE_CTRL:    next_rdata[7:0] = line_ctrl;
      `OFS_MODEM_CTRL:   next_rdata[7:0] = modem_ctrl;
      `OFS_LINE_STATUS:  next_rdata[7:0] = line_status_register;
      `OFS_INT_STATUS:   next_rdata[2:0] = {line_status_irq, rx_timeout_irq, rx_data_irq};
      `OFS_BAUD_DIV:     next_rdata[15:0] = baud_div;
      `OFS_MODEM_STATUS: next_rdata[3:0] = loop ? 4'h0 : ~ms_s2;
      `OFS_IR_CTRL:      next_rdata[7:0] = ir_ctrl;
      `OFS_ENH_MULTI:    next_rdata[7:0] = enh_multi;
      `OFS_SLAVE_ADDR:   next_rdata[7:0] = slave_addr;
      default:           rd_ok = 1'b0;
    endcase
  end
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'h0;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= (rd_ok && !(araddr == `OFS_RX_HOLDING && count == '0)) ? next_rdata : 32'h0;
      rresp  <= rd_ok ? 2'h0 : 2'h2;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_start_reject: assert property (
    rx_state == RX_START && tick && rx_sub == `START_MID && rx_bit |=> rx_state == RX_IDLE)
    else $error("false start bit accepted");
  a_pop_advance: assert property (
    pop && !push && !fifo_clr |=> count == $past(count) - 1'b1 && rd_ptr == $past(rd_ptr) + 1'b1)
    else $error("read did not advance fifo");
  a_data_irq: assert property (
    int_enable[0] && !fifo_ctrl[0] && count != '0 |=> rx_data_irq)
    else $error("data ready interrupt missing");
  a_timeout_irq: assert property (
    int_enable[0] && timeout |=> rx_timeout_irq)
    else $error("timeout interrupt missing");
  a_dir_release: assert property (
    auto_485 && !loop && tx_state == TX_SHIFT ##1 tx_state == TX_IDLE && !tx_hold_full
    |=> direction_control_out == enh_multi[5])
    else $error("direction not released after stop bit");
  a_dir_lead: assert property (
    tx_state == TX_LEAD && auto_485 && !loop |-> direction_control_out == !enh_multi[5])
    else $error("direction not asserted before start bit");
  a_md_tag: assert property (
    push && multidrop |=> fifo_mem[$past(wr_ptr)][8] == $past(rx_par))
    else $error("multidrop tag differs from ninth bit");
  a_addr_drop: assert property (
    rx_done && auto_addr && is_addr && !match && !pop && !fifo_clr |=> count == $past(count))
    else $error("mismatched address stored");
  a_loop_quiet: assert property (
    loop |=> serial_tx_out && dtr_n_out)
    else $error("loopback outputs not quiet");
  a_ir_idle: assert property (
    !ir_en |=> infrared_tx_out == $past(ir_ctrl[1]))
    else $error("infrared idle level wrong");
  c_start_ok: cover property (rx_state == RX_START ##[1:300] rx_state == RX_DATA);
  c_addr_match: cover property (rx_done && auto_addr && is_addr && match);
  c_timeout: cover property (rx_timeout_irq);
  c_tx_frame: cover property (tx_state == TX_LEAD ##[1:300] tx_state == TX_SHIFT);
endmodule : uart_rx_line
`default_nettype wire

/* verif/line_partner.sv */
// Serial line partner sending framed characters
`timescale 1ns/10ps
`default_nettype none
module line_partner #(
  parameter int BIT_CYC = 80
) (
  input  wire logic aclk,
  output logic      line_out,
  output logic      ir_out
);
  // Line rests at mark, infrared dark, between frames
  initial line_out = 1'b1;
  initial ir_out = 1'b0;
  // Start, eight data bits lsb first, optional ninth, stop
  task automatic send(input logic [7:0] d, input logic nb, input bit use_nb);
    logic [10:0] f;
    f = {1'b1, nb, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || use_nb) begin
        line_out <= f[i];
        ir_out   <= !f[i];
        repeat (BIT_CYC * 3 / 16) @(posedge aclk);
        ir_out   <= 1'b0;
        repeat (BIT_CYC - BIT_CYC * 3 / 16) @(posedge aclk);
      end
    end
  endtask : send
endmodule : line_partner
`default_nettype wire

/* verif/uart_rx_line_tb_top.sv */
// Testbench of the receive channel
`timescale 1ns/10ps
`default_nettype none
module uart_rx_line_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, serial_rx_in, serial_tx_out, direction_control_out, dtr_n_out;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  wstrb;
  logic [1:0]  rresp, gresp, bresp;
  logic [3:0]  msn;
  logic        irrx, irtx, rx_irq, to_irq, ls_irq;
  int          fails, num_checks;
  uart_rx_line dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .serial_rx_in, .serial_tx_out, .infrared_rx_in(irrx), .infrared_tx_out(irtx),
    .direction_control_out, .dtr_n_out, .modem_status_n_in(msn), .rx_data_irq(rx_irq),
    .rx_timeout_irq(to_irq), .line_status_irq(ls_irq));
  line_partner p_u (.aclk(aclk), .line_out(serial_rx_in), .ir_out(irrx));
  // Clock of 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Comparison and report
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic give_up;
    fails++;
    give_verdict;
  endtask : give_up
  // Register write: address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ao = 1, wo = 1, bo = 1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; bo; n++) begin
      @(posedge aclk);
      if (n > 99) give_up;
      if (bvalid) begin
        bo = 0;
        gresp = bresp;
      end
      if (ao && awready) begin
        awvalid <= 1'b0;
        ao = 0;
      end
      if (wo && wready) begin
        wvalid <= 1'b0;
        wo = 0;
      end
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  // Register read into got and gresp
  task automatic rd(input logic [7:0] a);
    bit ao = 1, ro = 1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; ro; n++) begin
      @(posedge aclk);
      if (n > 99) give_up;
      if (rvalid) begin
        got = rdata;
        gresp = rresp;
        ro = 0;
      end
      if (ao && arready) begin
        arvalid <= 1'b0;
        ao = 0;
      end
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // Register defaults, writable address, unmapped place
  task automatic s_regs;
    rd(8'hf0); chk("multifunction reset", got, 32'h0);
    wr(8'hf4, 32'ha5); chk("write resp", {30'h0, gresp}, 32'h0);
    rd(8'hf4); chk("slave address", got, 32'ha5);
    rd(8'h40); chk("unmapped resp", {30'h0, gresp}, 32'h2);
    rd(8'h24); chk("modem status", got, 32'hf);
  endtask : s_regs
  // Two characters back to back, read in order
  task automatic s_fifo;
    wr(8'h08, 32'h5);
    wr(8'h0c, 32'h1);
    wr(8'h10, 32'h3);
    p_u.send(8'h3c, 1'b0, 0);
    p_u.send(8'hc3, 1'b0, 0);
    chk("data irq", rx_irq, 32'h1);
    rd(8'h18); chk("data ready", got[0], 32'h1);
    repeat (3400) @(posedge aclk);
    chk("early timeout", to_irq, 32'h0);
    repeat (200) @(posedge aclk);
    chk("timeout irq", to_irq, 32'h1);
    rd(8'h00); chk("first byte", got, 32'h3c);
    rd(8'h00); chk("second byte", got, 32'hc3);
    rd(8'h18); chk("fifo empty", got[0], 32'h0);
  endtask : s_fifo
  // Infrared idle levels and pulses decoded into a byte
  task automatic s_ir;
    chk("ir idle low", irtx, 32'h0);
    wr(8'h28, 32'h12);
    chk("ir idle high", irtx, 32'h1);
    p_u.send(8'h96, 1'b0, 0);
    rd(8'h00); chk("infrared byte", got, 32'h96);
    wr(8'h28, 32'h0);
  endtask : s_ir
  // Bad parity then good parity, tags follow the head
  task automatic s_parity;
    wr(8'h10, 32'h1b);
    p_u.send(8'h01, 1'b0, 1);
    p_u.send(8'h03, 1'b0, 1);
    rd(8'h18); chk("parity tag", got[2], 32'h1);
    rd(8'h00); chk("tagged byte", got, 32'h01);
    rd(8'h18); chk("head tag", got[2], 32'h0);
    rd(8'h00);
  endtask : s_parity
  // Address filtering in multidrop mode
  task automatic s_multi;
    wr(8'h10, 32'h0b);
    wr(8'hf0, 32'hc0);
    p_u.send(8'h11, 1'b1, 1);
    p_u.send(8'h22, 1'b0, 1);
    p_u.send(8'ha5, 1'b1, 1);
    p_u.send(8'h33, 1'b0, 1);
    chk("line irq", ls_irq, 32'h1);
    rd(8'h18); chk("address tag", got[2], 32'h1);
    rd(8'h00); chk("matched address", got, 32'ha5);
    rd(8'h18); chk("data tag", got[2], 32'h0);
    rd(8'h00); chk("data after match", got, 32'h33);
    rd(8'h18); chk("nothing dropped kept", got[0], 32'h0);
    wr(8'hf0, 32'h0);
  endtask : s_multi
  // Automatic direction around one transmitted frame
  task automatic s_485;
    wr(8'hf0, 32'h10);
    chk("dir idle", direction_control_out, 32'h0);
    wr(8'h04, 32'h55);
    chk("dir lead", direction_control_out, 32'h1);
    chk("line before dir", serial_tx_out, 32'h1);
    repeat (850) @(posedge aclk);
    chk("dir held", direction_control_out, 32'h1);
    repeat (100) @(posedge aclk);
    chk("dir released", direction_control_out, 32'h0);
    wr(8'hf0, 32'h30);
    chk("dir inverted", direction_control_out, 32'h1);
    wr(8'hf0, 32'h0);
  endtask : s_485
  // Loopback returns the sent byte while outputs rest
  task automatic s_loop;
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h13);
    chk("dtr off", dtr_n_out, 32'h1);
    chk("rts off", direction_control_out, 32'h1);
    rd(8'h24); chk("status ignored", got, 32'h0);
    wr(8'h04, 32'h69);
    got = 32'h0;
    for (int n = 0; !got[0]; n++) begin
      if (n > 499) give_up;
      chk("tx mark", serial_tx_out, 32'h1);
      rd(8'h18);
    end
    rd(8'h00); chk("looped byte", got, 32'h69);
  endtask : s_loop
  // Reset, then the scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb, msn} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_regs;
    s_fifo;
    s_ir;
    s_parity;
    s_multi;
    s_485;
    s_loop;
    give_verdict;
  end
endmodule : uart_rx_line_tb_top
`default_nettype wire
